/* core/lsc_core.sv */
// Purpose: Load output decision and streetlight timer with PWM dimming on
//          the transmit pin, registers reached over AHB-Lite.
// Assumes: battCv and panelCv come from logic on clk_sys in 10 mV units.
// Notes:   The timer program is restored from non-volatile storage at reset.
// Behaviour
// - Mode conventional one: off below 11.10V, on above 13.10V.
// - Mode conventional two: off below 11.80V, on above 14.00V.
// - User mode one: off below low threshold, on above high threshold.
// - User mode two: on only between low and high thresholds.
// - Energy mode: thresholds apply, once on stay on for preset minutes.
// - Forced modes act at once; sensing modes need two minutes' hold.
// - Jumper on serial pin selects mode unless jumper use is disabled.
// - Low-battery load decision overrides the lighting timer.
// - Switch closed only when decision on and dim level above zero.
// - Unsynchronised timer assumes a twelve-hour night.
// - Sunset: none, hours then dim two, midnight then dim two, or sunrise.
// - Sunrise: off, or on some hours before predicted sunrise.
// - Solar midnight is halfway between sunset and next sunrise.
// - Five days to sync; unsynced midnight is six hours after sunset.
// - Timer program is kept in non-volatile storage.
// - Switch-on dim level is sent on transmit pin in dimming mode.
// - Midnight shift in minutes applies only to midnight moments.
// - Day at least 0.5V above night, 11.4V lowest, zero gives defaults.
// - Day/night change must persist a delay of 0 to 60 minutes.
// - Dim level ramps one point per set seconds, zero steps at once.
// - Dimming output is 160Hz PWM, normal or inverted polarity.
// - Virtual load mode drives transmit pin from the load switch.
module lsc_core #(
   parameter int CYC_PER_SEC = lsc_pkg::CLK_HZ,
   parameter int PWM_SLOT_CYC = lsc_pkg::PWM_SLOT_DEF
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [15:0] battCv,
   input wire logic [15:0] panelCv,
   input wire logic jumperPin,
   input wire lsc_pkg::lsc_prog_t nvRdData,
   output lsc_pkg::lsc_prog_t nvWrData,
   output logic nvWrEn,
   output logic loadSwitch,
   output logic txOut,
   output logic txOe
);
   import lsc_pkg::*;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   logic wrPend_reg;
   logic [7:0] wrAddr_reg;
   logic [31:0] rdMux;
   logic busAcc;
   logic regWr;
   lsc_mode_t loadMode_reg;
   logic jmpDis_reg;
   lsc_tx_t txFunc_reg;
   logic slEn_reg;
   logic [15:0] vLow_reg;
   logic [15:0] vHigh_reg;
   logic [15:0] aesMin_reg;
   lsc_prog_t prog_reg;
   logic [15:0] nightLv_reg;
   logic [15:0] dayLv_reg;
   logic nvLoad_reg;
   logic decision_reg;
   logic isNight_reg;
   logic [2:0] syncDays_reg;
   logic [6:0] dimLevel_reg;
   logic jmpMeta_reg;
   logic jmpSync_reg;
   logic synced;

   // Zero wait states; the bus stalls while the block is frozen.
   assign hreadyout = clkEn;
   assign hresp = 1'b0;
   assign busAcc = hsel && htrans[1] && hready;
   assign regWr = wrPend_reg && clkEn;

   always_comb begin
      unique case (haddr[7:0])
         OFS_CTRL: rdMux = {24'h0, slEn_reg, 1'b0, txFunc_reg, jmpDis_reg,
                            loadMode_reg};
         OFS_THRESH: rdMux = {vHigh_reg, vLow_reg};
         OFS_ENERGY: rdMux = {16'h0, aesMin_reg};
         OFS_PROG0: rdMux = prog_reg[31:0];
         OFS_PROG1: rdMux = prog_reg[63:32];
         OFS_DETECT: rdMux = {dayLv_reg, nightLv_reg};
         OFS_STATUS: rdMux = {20'h0, !jmpDis_reg, dimLevel_reg, synced,
                              isNight_reg, loadSwitch, decision_reg};
         default: rdMux = 32'h0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         hrdata <= 32'h0;
      end else if (clkEn) begin
         wrPend_reg <= busAcc && hwrite;
         wrAddr_reg <= haddr[7:0];
         if (busAcc && !hwrite) begin
            hrdata <= rdMux;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         loadMode_reg <= MODE_CONV1;
         jmpDis_reg <= 1'b0;
         txFunc_reg <= TX_COMM;
         slEn_reg <= 1'b0;
         vLow_reg <= VLOW_RST;
         vHigh_reg <= VHIGH_RST;
         aesMin_reg <= 16'h0000;
         nightLv_reg <= 16'h0000;
         dayLv_reg <= 16'h0000;
      end else if (regWr) begin
         if (wrAddr_reg == OFS_CTRL) begin
            loadMode_reg <= lsc_mode_t'(hwdata[2:0]);
            jmpDis_reg <= hwdata[3];
            txFunc_reg <= lsc_tx_t'(hwdata[5:4]);
            slEn_reg <= hwdata[7];
         end
         if (wrAddr_reg == OFS_THRESH) begin
            vLow_reg <= hwdata[15:0];
            vHigh_reg <= hwdata[31:16];
         end
         if (wrAddr_reg == OFS_ENERGY) begin
            aesMin_reg <= hwdata[15:0];
         end
         if (wrAddr_reg == OFS_DETECT) begin
            nightLv_reg <= hwdata[15:0];
            dayLv_reg <= hwdata[31:16];
         end
      end
   end

   // ----------------------------------------------------------------
   // Timer program with non-volatile backing
   // ----------------------------------------------------------------
   logic progWr;
   assign progWr = regWr && (wrAddr_reg == OFS_PROG0
                             || wrAddr_reg == OFS_PROG1);

   // The stored program is taken one cycle after reset so a battery
   // removal does not lose the lighting schedule.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         prog_reg <= PROG_RST;
         nvLoad_reg <= 1'b1;
         nvWrEn <= 1'b0;
      end else if (clkEn) begin
         nvWrEn <= progWr;
         if (nvLoad_reg) begin
            prog_reg <= nvRdData;
            prog_reg.pad <= 5'h00;
            nvLoad_reg <= 1'b0;
         end else if (progWr && wrAddr_reg == OFS_PROG0) begin
            prog_reg[31:0] <= {5'h00, hwdata[26:0]};
         end else if (progWr) begin
            prog_reg[63:32] <= hwdata;
         end
      end
   end
   assign nvWrData = prog_reg;

   // ----------------------------------------------------------------
   // Time base and jumper synchroniser
   // ----------------------------------------------------------------
   logic [31:0] cycCnt_reg;
   logic [5:0] secOfMin_reg;
   logic secTick;
   logic minTick;
   assign secTick = clkEn && (cycCnt_reg == 32'(CYC_PER_SEC - 1));
   assign minTick = secTick && (secOfMin_reg == 6'h3b);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cycCnt_reg <= 32'h0;
         secOfMin_reg <= 6'h00;
         jmpMeta_reg <= 1'b1;
         jmpSync_reg <= 1'b1;
      end else if (clkEn) begin
         jmpMeta_reg <= jumperPin;
         jmpSync_reg <= jmpMeta_reg;
         cycCnt_reg <= secTick ? 32'h0 : cycCnt_reg + 32'h1;
         if (secTick) begin
            secOfMin_reg <= minTick ? 6'h00 : secOfMin_reg + 6'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Load decision
   // ----------------------------------------------------------------
   lsc_mode_t effMode;
   logic [15:0] thrLo;
   logic [15:0] thrHi;
   logic onCond;
   logic offCond;
   logic [6:0] swDly_reg;
   logic aesRun_reg;
   logic aesDone_reg;
   logic [15:0] aesCnt_reg;

   // A fitted jumper pulls the pin low.
   assign effMode = jmpDis_reg ? loadMode_reg
                  : (jmpSync_reg ? MODE_CONV1 : MODE_CONV2);

   always_comb begin
      thrLo = vLow_reg;
      thrHi = vHigh_reg;
      if (effMode == MODE_CONV1 || effMode == MODE_LIFE) begin
         thrLo = CONV1_LOW;
         thrHi = CONV1_HIGH;
      end else if (effMode == MODE_CONV2) begin
         thrLo = CONV2_LOW;
         thrHi = CONV2_HIGH;
      end
      if (effMode == MODE_USER2) begin
         offCond = battCv < thrLo || battCv > thrHi;
         onCond = !offCond;
      end else begin
         offCond = battCv < thrLo;
         onCond = battCv > thrHi && !aesDone_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         decision_reg <= 1'b0;
         swDly_reg <= 7'h00;
         aesRun_reg <= 1'b0;
         aesDone_reg <= 1'b0;
         aesCnt_reg <= 16'h0000;
      end else if (clkEn) begin
         if (offCond) begin
            aesDone_reg <= 1'b0;
         end
         if (effMode == MODE_OFF || effMode == MODE_ON) begin
            decision_reg <= (effMode == MODE_ON);
            swDly_reg <= 7'h00;
            aesRun_reg <= 1'b0;
         end else if (aesRun_reg && !offCond) begin
            swDly_reg <= 7'h00;
            if (minTick) begin
               aesCnt_reg <= aesCnt_reg - 16'h0001;
            end
            if (effMode != MODE_ENERGY
                || (minTick && aesCnt_reg <= 16'h0001)) begin
               decision_reg <= 1'b0;
               aesRun_reg <= 1'b0;
               aesDone_reg <= (effMode == MODE_ENERGY);
            end
         end else if (decision_reg ? offCond : onCond) begin
            if (secTick) begin
               if (swDly_reg == SWITCH_DELAY_S - 7'h01) begin
                  decision_reg <= !decision_reg;
                  swDly_reg <= 7'h00;
                  aesRun_reg <= !decision_reg && effMode == MODE_ENERGY;
                  aesCnt_reg <= aesMin_reg;
               end else begin
                  swDly_reg <= swDly_reg + 7'h01;
               end
            end
         end else begin
            swDly_reg <= 7'h00;
            aesRun_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Day and night detection
   // ----------------------------------------------------------------
   logic [15:0] nightThr;
   logic [15:0] dayThr;
   logic [5:0] dlyMin;
   logic [11:0] dnLimit;
   logic [11:0] dnCnt_reg;
   logic dnCand;
   logic dnFlip;

   always_comb begin
      nightThr = NIGHT_DEF;
      dayThr = DAY_DEF;
      if (nightLv_reg != 16'h0000) begin
         nightThr = nightLv_reg < NIGHT_DEF ? NIGHT_DEF : nightLv_reg;
         dayThr = dayLv_reg < nightThr + DAY_MARGIN ? nightThr + DAY_MARGIN
                : dayLv_reg;
      end
   end

   assign dlyMin = prog_reg.dnDelay > DN_DELAY_MAX ? DN_DELAY_MAX
                 : prog_reg.dnDelay;
   assign dnLimit = 12'(dlyMin) * 12'h03c;
   assign dnCand = isNight_reg ? panelCv > dayThr : panelCv < nightThr;
   assign dnFlip = dnCand && (dnLimit == 12'h000
                  || (secTick && dnCnt_reg == dnLimit - 12'h001));

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         isNight_reg <= 1'b0;
         dnCnt_reg <= 12'h000;
      end else if (clkEn) begin
         if (dnFlip) begin
            isNight_reg <= !isNight_reg;
            dnCnt_reg <= 12'h000;
         end else if (!dnCand) begin
            dnCnt_reg <= 12'h000;
         end else if (secTick) begin
            dnCnt_reg <= dnCnt_reg + 12'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Night clock and synchronisation
   // ----------------------------------------------------------------
   logic [11:0] nightMin_reg;
   logic [11:0] measNight_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         nightMin_reg <= 12'h000;
         measNight_reg <= DAY_HALF_MIN;
         syncDays_reg <= 3'h0;
      end else if (clkEn) begin
         if (dnFlip && !isNight_reg) begin
            nightMin_reg <= 12'h000;
         end else if (isNight_reg && minTick && nightMin_reg != 12'hfff) begin
            nightMin_reg <= nightMin_reg + 12'h001;
         end
         if (progWr) begin
            syncDays_reg <= 3'h0;
         end else if (dnFlip && isNight_reg) begin
            measNight_reg <= nightMin_reg;
            if (syncDays_reg != SYNC_DAYS) begin
               syncDays_reg <= syncDays_reg + 3'h1;
            end
         end
      end
   end
   assign synced = syncDays_reg == SYNC_DAYS;

   // ----------------------------------------------------------------
   // Dim target and ramp
   // ----------------------------------------------------------------
   logic [11:0] predRise;
   logic signed [13:0] nmS;
   logic signed [13:0] midAt;
   logic signed [13:0] preAt;
   logic [6:0] dimTgt;
   logic [6:0] dimCnt_reg;

   assign predRise = synced ? measNight_reg : DAY_HALF_MIN;
   assign nmS = $signed({2'b00, nightMin_reg});
   assign midAt = $signed({2'b00, synced ? {1'b0, measNight_reg[11:1]}
                  : MID_UNSYNC_MIN})
                + $signed({{2{prog_reg.midShift[11]}},
                           prog_reg.midShift});
   assign preAt = $signed({2'b00, predRise})
                - $signed({2'b00, 12'(prog_reg.riseHours) * 12'h03c});

   always_comb begin
      dimTgt = DIM_FULL;
      if (slEn_reg) begin
         dimTgt = 7'h00;
         if (isNight_reg) begin
            unique case (prog_reg.setAct)
               SET_NONE: dimTgt = 7'h00;
               SET_HOURS: dimTgt = nightMin_reg
                        < 12'(prog_reg.setHours) * 12'h03c
                        ? prog_reg.dim1 : prog_reg.dim2;
               SET_MID: dimTgt = nmS < midAt ? prog_reg.dim1 : prog_reg.dim2;
               SET_RISE: dimTgt = prog_reg.dim1;
            endcase
            if (prog_reg.riseAct && prog_reg.setAct != SET_RISE
                && nmS >= preAt) begin
               dimTgt = prog_reg.dimRise;
            end
         end
         if (dimTgt > DIM_FULL) begin
            dimTgt = DIM_FULL;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dimLevel_reg <= 7'h00;
         dimCnt_reg <= 7'h00;
      end else if (clkEn) begin
         if (dimLevel_reg == dimTgt) begin
            dimCnt_reg <= 7'h00;
         end else if (prog_reg.dimSpeed == 7'h00) begin
            dimLevel_reg <= dimTgt;
         end else if (secTick) begin
            if (dimCnt_reg >= prog_reg.dimSpeed - 7'h01
                || dimCnt_reg >= DIM_SPEED_MAX) begin
               dimCnt_reg <= 7'h00;
               dimLevel_reg <= dimLevel_reg < dimTgt ? dimLevel_reg + 7'h01
                             : dimLevel_reg - 7'h01;
            end else begin
               dimCnt_reg <= dimCnt_reg + 7'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Load switch and transmit pin
   // ----------------------------------------------------------------
   logic [31:0] slotCyc_reg;
   logic [6:0] slotIdx_reg;
   logic [6:0] effDim;
   logic pwmHigh;

   // A low battery forces the light off whatever the timer asks.
   assign effDim = decision_reg ? dimLevel_reg : 7'h00;
   assign pwmHigh = slotIdx_reg < effDim;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         slotCyc_reg <= 32'h0;
         slotIdx_reg <= 7'h00;
         loadSwitch <= 1'b0;
         txOut <= 1'b1;
         txOe <= 1'b0;
      end else if (clkEn) begin
         if (slotCyc_reg == 32'(PWM_SLOT_CYC - 1)) begin
            slotCyc_reg <= 32'h0;
            slotIdx_reg <= slotIdx_reg == DIM_FULL - 7'h01 ? 7'h00
                         : slotIdx_reg + 7'h01;
         end else begin
            slotCyc_reg <= slotCyc_reg + 32'h1;
         end
         loadSwitch <= decision_reg && dimLevel_reg != 7'h00;
         txOe <= txFunc_reg != TX_COMM;
         unique case (txFunc_reg)
            TX_COMM: txOut <= 1'b1;
            TX_PWM: txOut <= pwmHigh;
            TX_PWM_INV: txOut <= !pwmHigh;
            TX_VLOAD: txOut <= decision_reg
                             && dimLevel_reg != 7'h00;
         endcase
      end
   end
endmodule : lsc_core

/* inc/lsc_pkg.sv */
// Purpose: Shared constants and types of the load output and streetlight
//          controller.
// Assumes: Voltages are in units of 10 mV for a 12 V system.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package lsc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_THRESH = 8'h04;
   localparam logic [7:0] OFS_ENERGY = 8'h08;
   localparam logic [7:0] OFS_PROG0 = 8'h0c;
   localparam logic [7:0] OFS_PROG1 = 8'h10;
   localparam logic [7:0] OFS_DETECT = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // ----------------------------------------------------------------
   // Voltage levels, 10 mV units
   // ----------------------------------------------------------------
   localparam logic [15:0] CONV1_LOW = 16'h0456;
   localparam logic [15:0] CONV1_HIGH = 16'h051e;
   localparam logic [15:0] CONV2_LOW = 16'h049c;
   localparam logic [15:0] CONV2_HIGH = 16'h0578;
   localparam logic [15:0] NIGHT_DEF = 16'h0474;
   localparam logic [15:0] DAY_DEF = 16'h04a6;
   localparam logic [15:0] DAY_MARGIN = 16'h0032;
   localparam logic [15:0] VLOW_RST = CONV1_LOW;
   localparam logic [15:0] VHIGH_RST = CONV1_HIGH;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int PWM_HZ = 160;
   localparam int PWM_STEPS = 100;
   localparam int PWM_SLOT_DEF = CLK_HZ / (PWM_HZ * PWM_STEPS);
   localparam int SWITCH_DELAY_MIN = 2;
   localparam logic [6:0] SWITCH_DELAY_S = 7'(SWITCH_DELAY_MIN * 60);
   localparam logic [11:0] DAY_HALF_MIN = 12'(12 * 60);
   localparam logic [11:0] MID_UNSYNC_MIN = 12'(6 * 60);
   localparam logic [2:0] SYNC_DAYS = 3'h5;
   localparam logic [5:0] DN_DELAY_MAX = 6'h3c;
   localparam logic [6:0] DIM_FULL = 7'h64;
   localparam logic [6:0] DIM_SPEED_MAX = 7'h63;

   // ----------------------------------------------------------------
   // Modes and program layout
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_OFF = 3'b000, MODE_LIFE = 3'b001, MODE_CONV1 = 3'b010,
      MODE_CONV2 = 3'b011, MODE_ON = 3'b100, MODE_USER1 = 3'b101,
      MODE_USER2 = 3'b110, MODE_ENERGY = 3'b111
   } lsc_mode_t;

   typedef enum logic [1:0] {
      TX_COMM = 2'b00, TX_PWM = 2'b01, TX_PWM_INV = 2'b10, TX_VLOAD = 2'b11
   } lsc_tx_t;

   typedef enum logic [1:0] {
      SET_NONE = 2'b00, SET_HOURS = 2'b01, SET_MID = 2'b10, SET_RISE = 2'b11
   } lsc_set_t;

   typedef struct packed {
      logic [11:0] midShift;
      logic [5:0] dnDelay;
      logic [6:0] dimSpeed;
      logic [6:0] dimRise;
      logic [4:0] pad;
      logic [6:0] dim2;
      logic [6:0] dim1;
      logic [4:0] riseHours;
      logic [4:0] setHours;
      logic riseAct;
      lsc_set_t setAct;
   } lsc_prog_t;

   localparam lsc_prog_t PROG_RST = '0;
endpackage : lsc_pkg

/* verification/lsc_core_chk.sv */
// Purpose: Port checker for the load and streetlight controller.
// Assumes: clkEn stays high through every bus transfer.
// Notes:   Tracks CTRL writes on the bus to know the transmit pin function.
module lsc_core_chk
   import lsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic nvWrEn,
   input wire logic loadSwitch,
   input wire logic txOut,
   input wire logic txOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic dpWr_reg, dpRd_reg, ctrlWr;
   logic [7:0] dpAddr_reg;
   logic [1:0] tx_reg;
   logic sl_reg;
   logic [3:0] age_reg;
   assign ctrlWr = dpWr_reg && dpAddr_reg == OFS_CTRL;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dpWr_reg <= 1'b0;
         dpRd_reg <= 1'b0;
         dpAddr_reg <= 8'h00;
      end else if (clkEn) begin
         dpWr_reg <= hsel & htrans[1] & hready & hwrite;
         dpRd_reg <= hsel & htrans[1] & hready & !hwrite;
         dpAddr_reg <= haddr[7:0];
      end
   end
   // Settle time after a CTRL write, so outputs may follow the new function.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_reg <= 2'h0;
         sl_reg <= 1'b0;
         age_reg <= 4'h0;
      end else if (ctrlWr) begin
         tx_reg <= hwdata[5:4];
         sl_reg <= hwdata[7];
         age_reg <= 4'h0;
      end else if (age_reg != 4'hf) begin
         age_reg <= age_reg + 4'h1;
      end
   end
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   ready_follow_a: assert property (hreadyout == clkEn)
      else $error("hreadyout differs from clkEn");
   unmapped_zero_a: assert property (dpRd_reg && dpAddr_reg > OFS_STATUS
      |-> hrdata == 32'h0) else $error("unmapped read not zero");
   nv_pulse_a: assert property (nvWrEn |=> !nvWrEn)
      else $error("nvWrEn longer than one cycle");
   nv_store_a: assert property (
      dpWr_reg && (dpAddr_reg == OFS_PROG0 || dpAddr_reg == OFS_PROG1)
      |-> ##[1:3] nvWrEn) else $error("program write not stored");
   // Streetlight off keeps the dim target at full, so the switch follows.
   forced_on_a: assert property (
      ctrlWr && hwdata[3:0] == 4'hc && !hwdata[7] |-> ##[1:5] loadSwitch)
      else $error("forced on late");
   forced_off_a: assert property (
      ctrlWr && hwdata[3:0] == 4'h8 |-> ##[1:5] !loadSwitch)
      else $error("forced off late");
   pwm_full_a: assert property (
      age_reg == 4'hf && tx_reg == TX_PWM && !sl_reg && loadSwitch
      |-> txOut) else $error("full light not full duty");
   pwm_inv_a: assert property (
      age_reg == 4'hf && tx_reg == TX_PWM_INV && !sl_reg && loadSwitch
      |-> !txOut) else $error("inverted full light not zero");
   vload_a: assert property (
      age_reg == 4'hf && tx_reg == TX_VLOAD |-> ##[0:1] txOut == loadSwitch)
      else $error("vload mismatch");
   oe_a: assert property (age_reg == 4'hf |-> txOe == (tx_reg != TX_COMM))
      else $error("txOe wrong for function");
endmodule : lsc_core_chk

bind lsc_core lsc_core_chk i_lsc_core_chk (.clk_sys, .rst_n, .clkEn, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .nvWrEn, .loadSwitch, .txOut, .txOe);

/* verification/lsc_lamp_model.sv */
// Purpose: LED driver dimming input seen from the transmit pin.
// Assumes: One PWM period is PERIOD clocks.
// Notes:   Reports the duty of each whole period in percent.
module lsc_lamp_model #(
   parameter int PERIOD = 200
) (
   input wire logic clk_sys,
   input wire logic txOut,
   output logic [7:0] dutyPct
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int hi = 0;
   initial dutyPct = 8'h00;
   always @(posedge clk_sys) begin
      if (cnt == PERIOD - 1) begin
         dutyPct <= 8'((hi + int'(txOut)) * 100 / PERIOD);
         hi <= 0;
         cnt <= 0;
      end else begin
         hi <= hi + int'(txOut);
         cnt <= cnt + 1;
      end
   end
endmodule : lsc_lamp_model

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the load output controller.
// Assumes: One second is ten clocks and a PWM slot two clocks.
// Notes:   The bench keeps the non-volatile program store itself.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lsc_pkg::*;
   logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, jumperPin = 1;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = '0;
   logic [15:0] battCv = 16'h04b0, panelCv = 16'h0000;
   logic hready, hreadyout, hresp, nvWrEn, loadSwitch, txOut, txOe;
   lsc_prog_t nvMem = PROG_RST, nvWrData;
   logic [7:0] duty;
   int n_fail = 0, compares = 0;
   always #5 clk_sys = ~clk_sys;
   assign hready = hreadyout;
   always @(posedge clk_sys) if (nvWrEn) nvMem <= nvWrData;
   lsc_core #(.CYC_PER_SEC(10), .PWM_SLOT_CYC(2)) i_lsc_core (.clk_sys,
      .rst_n, .clkEn(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .battCv,
      .panelCv, .jumperPin, .nvRdData(nvMem), .nvWrData, .nvWrEn,
      .loadSwitch, .txOut, .txOe);
   lsc_lamp_model i_lsc_lamp_model (.clk_sys, .txOut, .dutyPct(duty));
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // Two minutes is 1200 clocks: no change at 1000, settled by 1300.
   task step(input logic [15:0] v, input logic e);
      logic keep;
      keep = loadSwitch;
      battCv <= v;
      repeat (1000) @(posedge clk_sys);
      chk(32'(loadSwitch), 32'(keep), "load changed early");
      repeat (300) @(posedge clk_sys);
      chk(32'(loadSwitch), 32'(e), "load state");
   endtask : step
   task finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      #400000;
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h2, "ctrl reset");
      ahb(1'b0, OFS_THRESH, 32'h0);
      chk(rd, {VHIGH_RST, VLOW_RST}, "thresh reset");
      ahb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      step(16'h0528, 1'b1);
      step(16'h04b0, 1'b1);
      step(16'h044c, 1'b0);
      jumperPin <= 1'b0;
      step(16'h0528, 1'b0);
      step(16'h0582, 1'b1);
      step(16'h0492, 1'b0);
      ahb(1'b1, OFS_THRESH, 32'h04e2_04b0);
      ahb(1'b1, OFS_CTRL, 32'h0000_000d);
      step(16'h04ec, 1'b1);
      step(16'h04a6, 1'b0);
      ahb(1'b1, OFS_CTRL, 32'h0000_000e);
      step(16'h04c4, 1'b1);
      step(16'h04ec, 1'b0);
      battCv <= 16'h04c4;
      repeat (800) @(posedge clk_sys);
      battCv <= 16'h04ec;
      repeat (50) @(posedge clk_sys);
      step(16'h04c4, 1'b1);
      ahb(1'b1, OFS_CTRL, 32'h0000_0008);
      repeat (5) @(posedge clk_sys);
      chk(32'(loadSwitch), 32'h0, "forced off");
      // Two minutes on: off at the second minute tick, one to two minutes after switch-on.
      ahb(1'b1, OFS_ENERGY, 32'h0000_0002);
      ahb(1'b1, OFS_CTRL, 32'h0000_000f);
      step(16'h04ec, 1'b1);
      repeat (1300) @(posedge clk_sys);
      chk(32'(loadSwitch), 32'h0, "energy timed off");
      ahb(1'b1, OFS_CTRL, 32'h0000_001c);
      repeat (450) @(posedge clk_sys);
      chk(32'(duty), 32'd100, "pwm duty");
      ahb(1'b1, OFS_CTRL, 32'h0000_002c);
      repeat (450) @(posedge clk_sys);
      chk(32'(duty), 32'd0, "inverted duty");
      ahb(1'b1, OFS_CTRL, 32'h0000_003c);
      repeat (5) @(posedge clk_sys);
      chk({30'h0, txOut, loadSwitch}, 32'h3, "vload on");
      ahb(1'b1, OFS_CTRL, 32'h0000_0038);
      repeat (5) @(posedge clk_sys);
      chk({30'h0, txOut, loadSwitch}, 32'h0, "vload off");
      ahb(1'b1, OFS_PROG0, 32'h0123_4567);
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ahb(1'b0, OFS_PROG0, 32'h0);
      chk(rd, 32'h0123_4567, "program kept");
      // Night with sunrise action: the first dim level, 26, is shown.
      ahb(1'b1, OFS_CTRL, 32'h0000_009c);
      repeat (450) @(posedge clk_sys);
      chk(32'(duty), 32'd26, "dim level duty");
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h0000_01a7, "status at night");
      panelCv <= 16'h04b0;
      repeat (5) @(posedge clk_sys);
      chk(32'(loadSwitch), 32'h0, "day light off");
      finish_test();
   end
endmodule : tb_top
